// file: dpc_pkg.sv
// constants for the diskette and printer port configuration bank
package dpc_pkg;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 32;

   // logical device selects the 1 KiB half of the bus window
   localparam logic LDEV_DISK = 1'b0;
   localparam logic LDEV_PORT = 1'b1;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DISK_MODE   = 8'hF0;
   localparam logic [7:0] IDX_DISK_OPTION = 8'hF1;
   localparam logic [7:0] IDX_DRIVE_TYPES = 8'hF2;
   localparam logic [7:0] IDX_DISK_RSVD   = 8'hF3;
   localparam logic [7:0] IDX_DRIVE0_TIME = 8'hF4;
   localparam logic [7:0] IDX_DRIVE1_TIME = 8'hF5;
   localparam logic [7:0] IDX_PORT_MODE   = 8'hF0;
   localparam logic [7:0] IDX_PORT_MUX    = 8'hF1;

   // reset values
   localparam logic [7:0] RST_DISK_MODE   = 8'h0E;
   localparam logic [7:0] RST_DISK_OPTION = 8'h00;
   localparam logic [7:0] RST_DRIVE_TYPES = 8'hFF;
   localparam logic [7:0] RST_DRIVE_TIME  = 8'h00;
   localparam logic [7:0] RST_PORT_MODE   = 8'h3C;
   localparam logic [7:0] RST_PORT_MUX    = 8'h00;

   // writable bits of the per-drive registers (2, 5, 7 read zero)
   localparam logic [7:0] DRIVE_TIME_WMASK = 8'h5B;

   // field positions
   localparam int MODE_ENH_BIT      = 0;
   localparam int MODE_NOBURST_BIT  = 1;
   localparam int MODE_IF_LSB       = 2;
   localparam int MODE_SWAP_BIT     = 4;
   localparam int MODE_PUSHPULL_BIT = 6;
   localparam int MODE_TRISTATE_BIT = 7;
   localparam int OPT_DENS_LSB      = 2;
   localparam int OPT_BOOT_LSB      = 6;
   localparam int DRV_KIND_LSB      = 0;
   localparam int DRV_RATE_LSB      = 3;
   localparam int DRV_NOPRECOMP_BIT = 6;
   localparam int PMODE_THR_LSB     = 3;
   localparam int PMODE_PULSE_BIT   = 7;

   // field codes
   localparam logic [1:0] DENS_FORCE_ONE  = 2'h2;
   localparam logic [1:0] DENS_FORCE_ZERO = 2'h3;
   localparam logic [2:0] PMODE_PRINTER   = 3'h4;
   localparam logic [2:0] PMODE_SPP       = 3'h0;
   localparam int         PMODE_ECP_BIT   = 1;
   localparam logic [1:0] MUX_ONE_DRIVE   = 2'h1;
   localparam logic [1:0] MUX_TWO_DRIVES  = 2'h2;
   localparam logic [2:0] ECR_FIFO        = 3'h2;
   localparam logic [2:0] ECR_ECP         = 3'h3;
   localparam logic [2:0] ECR_TEST        = 3'h6;

   // pulsed interrupt low time
   localparam int CLK_NS      = 8;
   localparam int IRQ_PULSE_NS = 40;
   localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS;

   function automatic logic [ADDR_W-1:0] regAddr(input logic ldev,
                                                 input logic [7:0] idx);
      regAddr = {ldev, idx, 2'b00};
   endfunction
endpackage

// file: dpc_config_bank.sv
// diskette and printer port configuration bank with pin steering
//
// Operation
// - only hard reset loads register defaults
// - mode bit 0 selects enhanced floppy mode
// - mode bit 1 set means non-burst DMA
// - mode bits 3:2 select interface flavour
// - mode bit 4 swaps drive 0/1 selects
// - mode bit 6 chooses push-pull over open-drain
// - mode bit 7 tristates; port pins unaffected
// - option bits 3:2 force density output
// - option bits 7:6 name the boot drive
// - type register stores four two-bit drive kinds
// - index F3 reads as zero always
// - per-drive kind/rate fields; bits 2,5,7 zero
// - per-drive bit 6 disables write precompensation
// - drive 1 register mirrors drive 0 layout
// - port mode bits 2:0 select port mode
// - port mode bits 6:3 hold FIFO threshold
// - bit 7 set gives pulsed low interrupt, except in printer and SPP modes
// - bit 7 clear: follow acknowledge or level
// - mux bits 1:0 move drives to port pins
// - unselected interrupt pin stays high impedance
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module dpc_config_bank
   import dpc_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     sys_rst,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [dpc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [dpc_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]               pstrb,
   output logic                          pready,
   output logic [dpc_pkg::DATA_W-1:0]    prdata,
   output logic                          pslverr,
   input  wire logic [1:0]               driveSelInN,
   input  wire logic [1:0]               motorOnInN,
   input  wire logic                     densityIn,
   output logic [1:0]                    diskDriveSelN,
   output logic [1:0]                    diskMotorN,
   output logic [1:0]                    diskPinOe,
   output logic [1:0]                    portDriveSelN,
   output logic [1:0]                    portMotorN,
   output logic [1:0]                    portPinOe,
   output logic                          densityOut,
   output logic                          enhancedMode,
   output logic                          dmaNonBurst,
   output logic [1:0]                    interfaceMode,
   output logic                          bootValid,
   output logic                          bootDrive,
   output logic [7:0]                    driveKindStore,
   output logic [1:0]                    drive0Kind,
   output logic [1:0]                    drive0Rate,
   output logic                          drive0PrecompOff,
   output logic [1:0]                    drive1Kind,
   output logic [1:0]                    drive1Rate,
   output logic                          drive1PrecompOff,
   output logic [2:0]                    portMode,
   output logic [3:0]                    fifoThreshold,
   input  wire logic                     printerAckIn,
   input  wire logic                     ecpIrqReq,
   input  wire logic [2:0]               ecrMode,
   input  wire logic                     irqLineSelected,
   input  wire logic                     portIrqEnable,
   output logic                          portIrqOut,
   output logic                          portIrqOe
);
   import dpc_pkg::*;

   logic [7:0] diskMode_q;
   logic [7:0] diskOption_q;
   logic [7:0] driveTypes_q;
   logic [7:0] drive0Time_q;
   logic [7:0] drive1Time_q;
   logic [7:0] portMode_q;
   logic [7:0] portMux_q;

   // ---------------- APB slave ----------------
   logic       setupPhase;
   logic       wrAccept;
   logic       addrHit;
   logic [7:0] rdByte;
   logic [7:0] wrByte;

   assign setupPhase = psel && !penable;
   // zero-wait: pready raised for the first access cycle
   assign wrAccept   = psel && penable && pready && pwrite && pstrb[0]
                       && !pslverr;
   assign wrByte     = pwdata[7:0];

   always_comb begin
      addrHit = 1'b1;
      rdByte  = 8'h00;
      if (paddr == regAddr(LDEV_DISK, IDX_DISK_MODE)) begin
         rdByte = diskMode_q;
      end else if (paddr == regAddr(LDEV_DISK, IDX_DISK_OPTION)) begin
         rdByte = diskOption_q;
      end else if (paddr == regAddr(LDEV_DISK, IDX_DRIVE_TYPES)) begin
         rdByte = driveTypes_q;
      end else if (paddr == regAddr(LDEV_DISK, IDX_DISK_RSVD)) begin
         rdByte = 8'h00;
      end else if (paddr == regAddr(LDEV_DISK, IDX_DRIVE0_TIME)) begin
         rdByte = drive0Time_q;
      end else if (paddr == regAddr(LDEV_DISK, IDX_DRIVE1_TIME)) begin
         rdByte = drive1Time_q;
      end else if (paddr == regAddr(LDEV_PORT, IDX_PORT_MODE)) begin
         rdByte = portMode_q;
      end else if (paddr == regAddr(LDEV_PORT, IDX_PORT_MUX)) begin
         rdByte = portMux_q;
      end else begin
         addrHit = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setupPhase;
         pslverr <= setupPhase && !addrHit;
         if (setupPhase) begin
            prdata <= {24'h000000, (pwrite ? 8'h00 : rdByte)};
         end
      end
   end

   // ---------------- register bank ----------------
   // soft resets never reach these flops, only the hard reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         diskMode_q   <= RST_DISK_MODE;
         diskOption_q <= RST_DISK_OPTION;
         driveTypes_q <= RST_DRIVE_TYPES;
         drive0Time_q <= RST_DRIVE_TIME;
         drive1Time_q <= RST_DRIVE_TIME;
         portMode_q   <= RST_PORT_MODE;
         portMux_q    <= RST_PORT_MUX;
      end else if (wrAccept) begin
         if (paddr == regAddr(LDEV_DISK, IDX_DISK_MODE)) begin
            diskMode_q <= wrByte;
         end else if (paddr == regAddr(LDEV_DISK, IDX_DISK_OPTION)) begin
            diskOption_q <= wrByte;
         end else if (paddr == regAddr(LDEV_DISK, IDX_DRIVE_TYPES)) begin
            driveTypes_q <= wrByte;
         end else if (paddr == regAddr(LDEV_DISK, IDX_DRIVE0_TIME)) begin
            drive0Time_q <= wrByte & DRIVE_TIME_WMASK;
         end else if (paddr == regAddr(LDEV_DISK, IDX_DRIVE1_TIME)) begin
            drive1Time_q <= wrByte & DRIVE_TIME_WMASK;
         end else if (paddr == regAddr(LDEV_PORT, IDX_PORT_MODE)) begin
            portMode_q <= wrByte;
         end else if (paddr == regAddr(LDEV_PORT, IDX_PORT_MUX)) begin
            portMux_q <= wrByte;
         end
      end
   end

   // fields straight from the register flops
   assign enhancedMode  = diskMode_q[MODE_ENH_BIT];
   assign dmaNonBurst   = diskMode_q[MODE_NOBURST_BIT];
   // reserved code 10 is passed on untouched
   assign interfaceMode = diskMode_q[MODE_IF_LSB +: 2];
   assign bootValid     = !diskOption_q[OPT_BOOT_LSB+1];
   assign bootDrive     = diskOption_q[OPT_BOOT_LSB];
   assign driveKindStore = driveTypes_q;
   assign drive0Kind    = drive0Time_q[DRV_KIND_LSB +: 2];
   assign drive0Rate    = drive0Time_q[DRV_RATE_LSB +: 2];
   assign drive0PrecompOff = drive0Time_q[DRV_NOPRECOMP_BIT];
   assign drive1Kind    = drive1Time_q[DRV_KIND_LSB +: 2];
   assign drive1Rate    = drive1Time_q[DRV_RATE_LSB +: 2];
   assign drive1PrecompOff = drive1Time_q[DRV_NOPRECOMP_BIT];
   assign portMode      = portMode_q[2:0];
   assign fifoThreshold = portMode_q[PMODE_THR_LSB +: 4];

   // ---------------- density ----------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         densityOut <= 1'b0;
      end else begin
         case (diskOption_q[OPT_DENS_LSB +: 2])
            DENS_FORCE_ONE:  densityOut <= 1'b1;
            DENS_FORCE_ZERO: densityOut <= 1'b0;
            default:         densityOut <= densityIn;
         endcase
      end
   end

   // ---------------- drive select steering ----------------
   logic [1:0] posSelN;
   logic [1:0] posMotorN;
   logic [1:0] onPort;
   logic       pushPull;
   logic       tristate;

   always_comb begin
      if (diskMode_q[MODE_SWAP_BIT]) begin
         posSelN   = {driveSelInN[0], driveSelInN[1]};
         posMotorN = {motorOnInN[0], motorOnInN[1]};
      end else begin
         posSelN   = driveSelInN;
         posMotorN = motorOnInN;
      end
   end

   // codes 00 and 11 leave the port pins alone
   always_comb begin
      case (portMux_q[1:0])
         MUX_ONE_DRIVE:  onPort = 2'b10;
         MUX_TWO_DRIVES: onPort = 2'b11;
         default:        onPort = 2'b00;
      endcase
   end

   assign pushPull = diskMode_q[MODE_PUSHPULL_BIT];
   assign tristate = diskMode_q[MODE_TRISTATE_BIT];

   // in open-drain mode a pin is only ever driven low, so a shared
   // select line never fights another board
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         diskDriveSelN <= 2'b11;
         diskMotorN    <= 2'b11;
         diskPinOe     <= 2'b00;
         portDriveSelN <= 2'b11;
         portMotorN    <= 2'b11;
         portPinOe     <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (tristate || onPort[i]) begin
               diskDriveSelN[i] <= 1'b1;
               diskMotorN[i]    <= 1'b1;
               diskPinOe[i]     <= 1'b0;
            end else if (pushPull) begin
               diskDriveSelN[i] <= posSelN[i];
               diskMotorN[i]    <= posMotorN[i];
               diskPinOe[i]     <= 1'b1;
            end else begin
               diskDriveSelN[i] <= 1'b0;
               diskMotorN[i]    <= 1'b0;
               diskPinOe[i]     <= !posSelN[i] || !posMotorN[i];
            end
            // port pins ignore output type and tristate bits
            portDriveSelN[i] <= onPort[i] ? posSelN[i] : 1'b1;
            portMotorN[i]    <= onPort[i] ? posMotorN[i] : 1'b1;
            portPinOe[i]     <= onPort[i];
         end
      end
   end

   // ---------------- printer port interrupt ----------------
   logic       ackS1;
   logic       ackS2;
   logic       ackS3;
   logic       ackStable_q;
   logic       ackPrev_q;
   logic       ecpReqPrev_q;
   logic [2:0] pulseCnt_q;
   logic [2:0] pulseCnt_d;
   logic       plainMode;
   logic       pulsedType;
   logic       levelType;
   logic       irqAllowed;
   logic       irqEvent;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ackS1       <= 1'b1;
         ackS2       <= 1'b1;
         ackS3       <= 1'b1;
         ackStable_q <= 1'b1;
      end else begin
         ackS1 <= printerAckIn;
         ackS2 <= ackS1;
         ackS3 <= ackS2;
         if (ackS2 == ackS3) begin
            ackStable_q <= ackS3;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ackPrev_q    <= 1'b1;
         ecpReqPrev_q <= 1'b0;
      end else begin
         ackPrev_q    <= ackStable_q;
         ecpReqPrev_q <= ecpIrqReq;
      end
   end

   assign plainMode  = (portMode_q[2:0] == PMODE_PRINTER)
                       || (portMode_q[2:0] == PMODE_SPP);
   assign pulsedType = portMode_q[PMODE_PULSE_BIT] && !plainMode;
   assign levelType  = portMode_q[PMODE_ECP_BIT]
                       && ((ecrMode == ECR_FIFO) || (ecrMode == ECR_ECP)
                           || (ecrMode == ECR_TEST));
   assign irqAllowed = irqLineSelected && portIrqEnable;
   // acknowledge falling edge, or a new ECP level request
   assign irqEvent   = levelType ? (ecpIrqReq && !ecpReqPrev_q)
                                 : (ackPrev_q && !ackStable_q);

   always_comb begin
      if (!irqAllowed || !pulsedType) begin
         pulseCnt_d = 3'h0;
      end else if (irqEvent) begin
         pulseCnt_d = 3'(IRQ_PULSE_CYC);
      end else if (pulseCnt_q != 3'h0) begin
         pulseCnt_d = pulseCnt_q - 3'h1;
      end else begin
         pulseCnt_d = 3'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pulseCnt_q <= 3'h0;
      end else begin
         pulseCnt_q <= pulseCnt_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         portIrqOut <= 1'b0;
         portIrqOe  <= 1'b0;
      end else if (!irqAllowed) begin
         portIrqOut <= 1'b0;
         portIrqOe  <= 1'b0;
      end else if (pulsedType) begin
         portIrqOut <= 1'b0;
         portIrqOe  <= (pulseCnt_d != 3'h0);
      end else begin
         portIrqOut <= levelType ? ecpIrqReq : ackStable_q;
         portIrqOe  <= 1'b1;
      end
   end

   // ---------------- assertions ----------------
   // checked on the first edge after release, never while reset holds
   a_reset_defaults: assert property (@(posedge mclk) disable iff (sys_rst)
      $past(sys_rst) |-> (diskMode_q == RST_DISK_MODE)
         && (driveTypes_q == RST_DRIVE_TYPES)
         && (portMode_q == RST_PORT_MODE))
      else $error("bank defaults not loaded by reset");

   a_mode_write: assert property (@(posedge mclk) disable iff (sys_rst)
      wrAccept && (paddr == regAddr(LDEV_DISK, IDX_DISK_MODE))
      |=> (diskMode_q == $past(pwdata[7:0])) && (dmaNonBurst
         == $past(pwdata[MODE_NOBURST_BIT])))
      else $error("mode register write lost");

   a_rsvd_read: assert property (@(posedge mclk) disable iff (sys_rst)
      setupPhase && !pwrite
      && (paddr == regAddr(LDEV_DISK, IDX_DISK_RSVD))
      |=> pready && (prdata == 32'h00000000) && !pslverr)
      else $error("reserved slot read nonzero");

   a_drive_rozero: assert property (@(posedge mclk) disable iff (sys_rst)
      ((drive0Time_q & ~DRIVE_TIME_WMASK) == 8'h00)
      && ((drive1Time_q & ~DRIVE_TIME_WMASK) == 8'h00))
      else $error("read-only drive bits set");

   a_density_force: assert property (@(posedge mclk) disable iff (sys_rst)
      (diskOption_q[OPT_DENS_LSB +: 2] == DENS_FORCE_ZERO)
      ##1 (diskOption_q[OPT_DENS_LSB +: 2] == DENS_FORCE_ZERO)
      |-> !densityOut)
      else $error("density not forced low");

   a_disk_tristate: assert property (@(posedge mclk) disable iff (sys_rst)
      tristate ##1 tristate |-> (diskPinOe == 2'b00))
      else $error("diskette pins driven while tristated");

   a_swap_route: assert property (@(posedge mclk) disable iff (sys_rst)
      diskMode_q[MODE_SWAP_BIT] && pushPull && !tristate
      && (onPort == 2'b00)
      |=> diskDriveSelN == {$past(driveSelInN[0]),
                            $past(driveSelInN[1])})
      else $error("drive selects not swapped");

   a_mux_port: assert property (@(posedge mclk) disable iff (sys_rst)
      (portMux_q[1:0] == MUX_ONE_DRIVE) |=> (portPinOe == 2'b10)
      && !diskPinOe[1])
      else $error("drive 1 not moved to port pins");

   a_irq_unsel: assert property (@(posedge mclk) disable iff (sys_rst)
      !irqLineSelected |=> !portIrqOe)
      else $error("unselected interrupt pin driven");

   a_pulse_len: assert property (@(posedge mclk) disable iff (sys_rst)
      irqAllowed && pulsedType && irqEvent
      ##1 (irqAllowed && pulsedType)[*4]
      |-> portIrqOe && !portIrqOut)
      else $error("interrupt pulse too short");

endmodule // dpc_config_bank

// file: tb.sv
// self-checking bench for the diskette and printer port config bank
`timescale 1ns/1ps
module tb;
   import dpc_pkg::*;
   logic        mclk = 1'b0, sys_rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [10:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0]  pstrb = '0;
   logic        pready, pslverr, densityIn = 1'b0, densityOut;
   logic [1:0]  driveSelInN = 2'h3, motorOnInN = 2'h3;
   logic [1:0]  diskDriveSelN, diskMotorN, diskPinOe;
   logic [1:0]  portDriveSelN, portMotorN, portPinOe;
   logic        enhancedMode, dmaNonBurst, bootValid, bootDrive;
   logic [1:0]  interfaceMode, drive0Kind, drive0Rate, drive1Kind, drive1Rate;
   logic        drive0PrecompOff, drive1PrecompOff, portIrqOut, portIrqOe;
   logic [7:0]  driveKindStore;
   logic [2:0]  portMode, ecrMode = 3'h0;
   logic [3:0]  fifoThreshold;
   logic        printerAckIn = 1'b1, ecpIrqReq = 1'b0;
   logic        irqLineSelected = 1'b0, portIrqEnable = 1'b0;
   logic [7:0]  mdl [0:1][0:255];
   logic [7:0]  rdv, m, o;
   logic        err;
   int          failCount = 0, numChecks = 0, seed = 58, i, n;

   always #4 mclk = ~mclk;

   dpc_config_bank dpc_config_bank_i (.*);

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         failCount++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   function automatic logic mapped(input logic ld, input logic [7:0] x);
      return ld ? (x == 8'hF0 || x == 8'hF1) : (x >= 8'hF0 && x <= 8'hF5);
   endfunction

   task automatic mdlInit();
      foreach (mdl[a, b]) mdl[a][b] = 8'h00;
      mdl[0][8'hF0] = 8'h0E;
      mdl[0][8'hF2] = 8'hFF;
      mdl[1][8'hF0] = 8'h3C;
   endtask

   task automatic apb(input logic w, input logic ld, input logic [7:0] x,
                      input logic [7:0] d, input logic [3:0] stb);
      n = 0;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w;
      paddr <= {ld, x, 2'b00}; pwdata <= {24'h0, d}; pstrb <= stb;
      @(posedge mclk);
      penable <= 1'b1;
      do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 16);
      rdv = prdata[7:0];
      err = pslverr;
      if (pready !== 1'b1) begin
         failCount++;
         $display("[ERR] %0t no pready", $time);
      end
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // write then read back, model tracks writable bits only
   task automatic access(input logic ld, input logic [7:0] x,
                         input logic [7:0] d, input logic [3:0] stb);
      logic [7:0] wm;
      wm = (!ld && x == 8'hF3) ? 8'h00 :
           (!ld && x >= 8'hF4) ? 8'h5B : 8'hFF;
      apb(1'b1, ld, x, d, stb);
      chk(err, !mapped(ld, x));
      if (mapped(ld, x) && stb[0]) mdl[ld][x] = d & wm;
      apb(1'b0, ld, x, 8'h00, 4'h0);
      if (mapped(ld, x)) chk(rdv, mdl[ld][x]);
   endtask

   task automatic readAll();
      for (int x = 8'hF0; x <= 8'hF5; x++) begin
         apb(1'b0, 1'b0, x[7:0], 8'h00, 4'h0);
         chk(rdv, mdl[0][x]);
      end
      for (int x = 8'hF0; x <= 8'hF1; x++) begin
         apb(1'b0, 1'b1, x[7:0], 8'h00, 4'h0);
         chk(rdv, mdl[1][x]);
      end
   endtask

   task automatic chkOutputs();
      logic [1:0] s, mo, mv;
      logic       oe;
      m = mdl[0][8'hF0];
      o = mdl[0][8'hF1];
      chk(enhancedMode, m[0]);
      chk(dmaNonBurst, m[1]);
      chk(interfaceMode, m[3:2]);
      chk(bootValid, !o[7]);
      if (!o[7]) chk(bootDrive, o[6]);
      chk(driveKindStore, mdl[0][8'hF2]);
      chk({drive0PrecompOff, drive0Rate, drive0Kind},
          {mdl[0][8'hF4][6], mdl[0][8'hF4][4:3],
           mdl[0][8'hF4][1:0]});
      chk({drive1PrecompOff, drive1Rate, drive1Kind},
          {mdl[0][8'hF5][6], mdl[0][8'hF5][4:3],
           mdl[0][8'hF5][1:0]});
      chk(portMode, mdl[1][8'hF0][2:0]);
      chk(fifoThreshold, mdl[1][8'hF0][6:3]);
      chk(densityOut, o[3:2] == 2'h2 ? 1'b1 :
          o[3:2] == 2'h3 ? 1'b0 : densityIn);
      // swap first, then the mux moves pin positions
      s = m[4] ? {driveSelInN[0], driveSelInN[1]} : driveSelInN;
      mo = m[4] ? {motorOnInN[0], motorOnInN[1]} : motorOnInN;
      mv = mdl[1][8'hF1][1:0] == 2'h1 ? 2'b10 :
           mdl[1][8'hF1][1:0] == 2'h2 ? 2'b11 : 2'b00;
      for (int p = 0; p < 2; p++) begin
         if (mv[p]) begin
            chk(diskPinOe[p], 1'b0);
            chk(portPinOe[p], 1'b1);
            chk({portDriveSelN[p], portMotorN[p]}, {s[p], mo[p]});
         end else begin
            oe = !m[7] && (m[6] || !(s[p] && mo[p]));
            chk(diskPinOe[p], oe);
            chk(portPinOe[p], 1'b0);
            chk({portDriveSelN[p], portMotorN[p]}, 2'b11);
            if (oe) chk({diskDriveSelN[p], diskMotorN[p]},
                        m[6] ? {s[p], mo[p]} : 2'b00);
         end
      end
   endtask

   task automatic endOfTest();
      $display("checks %0d mismatches %0d", numChecks, failCount);
      if (failCount == 0 && numChecks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #60000;
      failCount++;
      endOfTest();
   end

   initial begin
      mdlInit();
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      readAll();
      $display("test reset values done");
      access(1'b0, 8'hF1, 8'hC4, 4'h0);
      for (i = 0; i < 60; i++) begin
         o = $random(seed);
         m = 8'hF0 + o[2:0] % 7;
         rdv = $random(seed);
         rdv &= (!o[3] && m == 8'hF0) ? 8'hDF : (!o[3] && m == 8'hF1) ?
                8'hCC : (o[3] && m == 8'hF1) ? 8'h03 : 8'hFF;
         access(o[3], m, rdv, 4'h1);
         @(posedge mclk);
         {driveSelInN, motorOnInN, densityIn} <= 5'($random(seed));
         tick(3);
         chkOutputs();
      end
      $display("test random access done");
      // hard reset in mid-run restores every default
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      mdlInit();
      readAll();
      $display("test second reset done");
      irqLineSelected <= 1'b1;
      portIrqEnable <= 1'b1;
      access(1'b1, 8'hF0, 8'hB9, 4'h1);
      tick(6);
      @(posedge mclk);
      printerAckIn <= 1'b0;
      n = 0;
      do begin tick(1); n++; end while (portIrqOe !== 1'b1 && n < 10);
      n = 0;
      while (portIrqOe === 1'b1 && portIrqOut === 1'b0 && n < 20) begin
         tick(1);
         n++;
      end
      chk(8'(n), 8'(IRQ_PULSE_CYC));
      access(1'b1, 8'hF0, 8'h39, 4'h1);
      tick(6);
      chk({portIrqOe, portIrqOut}, 2'b10);
      @(posedge mclk);
      printerAckIn <= 1'b1;
      tick(6);
      chk({portIrqOe, portIrqOut}, 2'b11);
      access(1'b1, 8'hF0, 8'h3A, 4'h1);
      ecrMode <= ECR_FIFO;
      ecpIrqReq <= 1'b1;
      tick(3);
      chk({portIrqOe, portIrqOut}, 2'b11);
      @(posedge mclk);
      ecpIrqReq <= 1'b0;
      tick(3);
      chk({portIrqOe, portIrqOut}, 2'b10);
      @(posedge mclk);
      irqLineSelected <= 1'b0;
      tick(3);
      chk(portIrqOe, 1'b0);
      $display("test interrupt done");
      endOfTest();
   end
endmodule // tb
